// ===== hw/pscr_pkg.sv
// What this block does
// R1: bit 5 of output power register switches frame clock output buffer off.
// R2: bit 4 of output power register switches bit clock output buffer off.
// R3: bit 3 switches channel A lane 1 buffer off; never done automatically.
// R4: bit 2 of output power register switches channel A lane 0 buffer off.
// R5: bit 1 switches channel B lane 1 buffer off; never done automatically.
// R6: bit 0 switches channel B lane 0 buffer off; never done automatically.
// R7: mask bit 3 set keeps sampling clock buffer powered during global sleep.
// R8: mask bit 2 set keeps reference amplifier powered during global sleep.
// R9: mask bit 1 set turns bandgap off in sleep; clear keeps it on.
// R10: control bit 7 picks pin role: 0 enters sleep, 1 issues sync.
// R11: toggling control bit 6 syncs only when enabled; software clears it.
// R12: control bit 5 set takes sync from register bit instead of pin.
// R13: control bit 3 set makes register reference and clock fields effective.
// R14: reference field bits 2-1: 00 internal, 01 external buffered, 10 direct.
// R15: control bit 0 with bit 3 selects single-ended clock, differential buffer off.
// R16: global sleep trigger powers down blocks chosen by the mask register.
// R17: reserved bits are written zero, held at zero and have no effect.
`default_nettype none
package pscr_pkg;
  localparam int          PSCR_AW          = 7;
  localparam int          PSCR_DW          = 8;
  localparam int          PSCR_FRAME_BITS  = 16;
  localparam logic [6:0]  PSCR_OFS_OUTPWR  = 7'h09;
  localparam logic [6:0]  PSCR_OFS_MASK    = 7'h0d;
  localparam logic [6:0]  PSCR_OFS_CTRL    = 7'h0e;
  localparam logic [7:0]  PSCR_RST_VAL     = 8'h00;
  // writable bits per register, the rest are reserved
  localparam logic [7:0]  PSCR_OUTPWR_MASK = 8'h3f;
  localparam logic [7:0]  PSCR_GMASK_MASK  = 8'h0e;
  localparam logic [7:0]  PSCR_CTRL_MASK   = 8'hef;
  // output power bit positions
  localparam int          PSCR_B_FRAME_CLOCK      = 5;
  localparam int          PSCR_B_BIT_CLOCK      = 4;
  localparam int          PSCR_B_A1        = 3;
  localparam int          PSCR_B_A0        = 2;
  localparam int          PSCR_B_B1        = 1;
  localparam int          PSCR_B_B0        = 0;
  // mask bit positions
  localparam int          PSCR_B_KEEP_CLK  = 3;
  localparam int          PSCR_B_KEEP_AMP  = 2;
  localparam int          PSCR_B_BG_OFF    = 1;
  // control bit positions
  localparam int          PSCR_B_PIN_SYNC  = 7;
  localparam int          PSCR_B_REG_SYNC  = 6;
  localparam int          PSCR_B_SYNC_EN   = 5;
  localparam int          PSCR_B_REF_REG   = 3;
  localparam int          PSCR_B_REF_HI    = 2;
  localparam int          PSCR_B_REF_LO    = 1;
  localparam int          PSCR_B_SE_CLK    = 0;
  // reference encodings
  localparam logic [1:0]  PSCR_REF_INT     = 2'h0;
  localparam logic [1:0]  PSCR_REF_EXT_BUF = 2'h1;
  localparam logic [1:0]  PSCR_REF_EXT     = 2'h2;
  localparam logic [1:0]  PSCR_REF_UNUSED  = 2'h3;

  typedef enum logic [1:0] {PSCR_IDLE, PSCR_ADDR, PSCR_DATA} pscr_phase_t;

  // analog and output power controls leaving the block
  typedef struct packed {
    logic       frame_clock_out_off;
    logic       bit_clock_out_off;
    logic       chan_a_lane1_off;
    logic       chan_a_lane0_off;
    logic       chan_b_lane1_off;
    logic       chan_b_lane0_off;
    logic       clock_buffer_off;
    logic       ref_amplifier_off;
    logic       bandgap_off;
    logic       sleep_active;
    logic       single_ended_clock;
    logic [1:0] reference_mode;
  } pscr_ctl_t;
endpackage
`default_nettype wire

// ===== hw/pscr_regs.sv
`default_nettype none
module pscr_regs
  import pscr_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst_n,
  input  wire logic      spi_sen_n,
  input  wire logic      spi_sclk,
  input  wire logic      spi_sdi,
  output var  logic      spi_sdo,
  output var  logic      spi_sdo_oe,
  input  wire logic      sync_or_sleep_pin,
  input  wire logic      reference_buffer_pin,
  input  wire logic      global_sleep_trigger,
  output var  pscr_ctl_t ctl,
  output var  logic      sync_pulse
);
  logic [7:0]              outpwr_reg;
  logic [7:0]              gmask_reg;
  logic [7:0]              ctrl_reg;
  logic                    sclk_reg;
  logic [4:0]              cnt_reg;
  logic [PSCR_FRAME_BITS-1:0] sh_reg;
  logic [7:0]              rd_reg;
  logic                    pin_reg;
  logic                    regsync_reg;
  logic                    read_reg;
  pscr_phase_t             phase_reg;
  pscr_phase_t             phase_next;

  // serial port edge detection; pins are taken as synchronous to mclk
  wire        sclk_rise = spi_sclk & ~sclk_reg & ~spi_sen_n;
  wire        sclk_fall = ~spi_sclk & sclk_reg & ~spi_sen_n;
  wire [PSCR_FRAME_BITS-1:0] sh_in = {sh_reg[PSCR_FRAME_BITS-2:0], spi_sdi};
  // last address bit is still on the data pin at the eighth rise, so decode the incoming word
  wire [6:0]  addr      = sh_in[PSCR_AW-1:0];
  // direction bit keeps moving through the shifter, so it is held once the address is in
  wire        is_read   = (phase_reg == PSCR_DATA) ? read_reg : sh_in[PSCR_AW];
  wire        addr_done = sclk_rise & (cnt_reg == 5'(PSCR_AW));
  wire        frame_end = sclk_rise & (cnt_reg == 5'(PSCR_FRAME_BITS - 1));
  wire        wr_stb    = frame_end & ~sh_reg[PSCR_FRAME_BITS-2];
  wire [6:0]  wr_addr   = sh_reg[PSCR_FRAME_BITS-3:PSCR_DW-1];
  wire [7:0]  wr_data   = sh_in[PSCR_DW-1:0];

  // address decode for writes and reads
  wire        wr_outpwr = wr_stb & (wr_addr == PSCR_OFS_OUTPWR);
  wire        wr_gmask  = wr_stb & (wr_addr == PSCR_OFS_MASK);
  wire        wr_ctrl   = wr_stb & (wr_addr == PSCR_OFS_CTRL);
  logic [7:0] rd_mux;
  always_comb begin
    if (addr == PSCR_OFS_OUTPWR) begin
      rd_mux = outpwr_reg;
    end else if (addr == PSCR_OFS_MASK) begin
      rd_mux = gmask_reg;
    end else if (addr == PSCR_OFS_CTRL) begin
      rd_mux = ctrl_reg;
    end else begin
      rd_mux = PSCR_RST_VAL;   // unmapped addresses read as zero
    end
  end

  // frame phase: address bits first, then data byte
  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      PSCR_IDLE: begin
        if (~spi_sen_n) begin
          phase_next = PSCR_ADDR;
        end
      end
      PSCR_ADDR: begin
        if (spi_sen_n) begin
          phase_next = PSCR_IDLE;
        end else if (addr_done) begin
          phase_next = PSCR_DATA;
        end
      end
      PSCR_DATA: begin
        if (spi_sen_n | frame_end) begin
          phase_next = PSCR_IDLE;
        end
      end
      default: begin
        phase_next = PSCR_IDLE;
      end
    endcase
  end

  // shift engine; a frame cut short by chip select never writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_reg  <= 1'b0;
      cnt_reg   <= '0;
      sh_reg    <= '0;
      phase_reg <= PSCR_IDLE;
    end else begin
      sclk_reg  <= spi_sclk;
      phase_reg <= phase_next;
      if (spi_sen_n | frame_end) begin
        cnt_reg <= '0;
      end else if (sclk_rise) begin
        cnt_reg <= cnt_reg + 5'h01;
      end
      if (sclk_rise) begin
        sh_reg <= sh_in;
      end
    end
  end

  // read data leaves msb first, changing on the falling clock edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_reg     <= '0;
      read_reg   <= 1'b0;
      spi_sdo    <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else begin
      if (phase_reg == PSCR_ADDR && addr_done) begin
        rd_reg   <= rd_mux;
        read_reg <= sh_in[PSCR_AW];
      end else if (sclk_fall && phase_reg == PSCR_DATA) begin
        spi_sdo <= rd_reg[PSCR_DW-1];
        rd_reg  <= {rd_reg[PSCR_DW-2:0], 1'b0};
      end
      spi_sdo_oe <= (phase_next == PSCR_DATA) & is_read & ~spi_sen_n;
    end
  end

  // register writes, reserved bits forced to zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      outpwr_reg <= PSCR_RST_VAL;
      gmask_reg  <= PSCR_RST_VAL;
      ctrl_reg   <= PSCR_RST_VAL;
    end else begin
      // R17: reserved bits held
      if (wr_outpwr) outpwr_reg <= wr_data & PSCR_OUTPWR_MASK;
      if (wr_gmask)  gmask_reg  <= wr_data & PSCR_GMASK_MASK;
      if (wr_ctrl)   ctrl_reg   <= wr_data & PSCR_CTRL_MASK;
    end
  end

  // derived control terms
  wire pin_is_sync = ctrl_reg[PSCR_B_PIN_SYNC];
  wire sync_by_reg = ctrl_reg[PSCR_B_SYNC_EN];
  wire ref_by_reg  = ctrl_reg[PSCR_B_REF_REG];
  // R10: pin role select
  wire pin_sleep   = sync_or_sleep_pin & ~pin_is_sync;
  wire pin_sync    = sync_or_sleep_pin & ~pin_reg & pin_is_sync;
  // R16: global sleep sources
  wire sleep       = global_sleep_trigger | pin_sleep;
  // R11: any toggle of the bit counts, not only a rise
  wire reg_sync    = (ctrl_reg[PSCR_B_REG_SYNC] ^ regsync_reg) & sync_by_reg;
  // R12: register sync replaces the pin
  wire sync_now    = sync_by_reg ? reg_sync : pin_sync;
  // R15: single ended clock only under register reference control
  wire se_clk      = ref_by_reg & ctrl_reg[PSCR_B_SE_CLK];
  // R13: pin chooses reference unless register control is set
  wire [1:0] ref_pin = reference_buffer_pin ? PSCR_REF_EXT_BUF : PSCR_REF_INT;
  // R14: reference field encoding, unused code passed through as is
  wire [1:0] ref_sel = ref_by_reg ? ctrl_reg[PSCR_B_REF_HI:PSCR_B_REF_LO] : ref_pin;

  // registered outputs so the analog side sees glitch free levels
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl         <= '0;
      sync_pulse  <= 1'b0;
      pin_reg     <= 1'b0;
      regsync_reg <= 1'b0;
    end else begin
      pin_reg     <= sync_or_sleep_pin;
      regsync_reg <= ctrl_reg[PSCR_B_REG_SYNC];
      sync_pulse  <= sync_now;
      // R1: frame clock buffer
      ctl.frame_clock_out_off <= outpwr_reg[PSCR_B_FRAME_CLOCK];
      // R2: bit clock buffer
      ctl.bit_clock_out_off   <= outpwr_reg[PSCR_B_BIT_CLOCK];
      // R3: lane 1 channel A
      ctl.chan_a_lane1_off    <= outpwr_reg[PSCR_B_A1];
      // R4: lane 0 channel A
      ctl.chan_a_lane0_off    <= outpwr_reg[PSCR_B_A0];
      // R5: lane 1 channel B
      ctl.chan_b_lane1_off    <= outpwr_reg[PSCR_B_B1];
      // R6: lane 0 channel B
      ctl.chan_b_lane0_off    <= outpwr_reg[PSCR_B_B0];
      // R7: clock buffer mask, also off in single ended mode
      ctl.clock_buffer_off    <= (sleep & ~gmask_reg[PSCR_B_KEEP_CLK]) | se_clk;
      // R8: reference amplifier mask
      ctl.ref_amplifier_off   <= sleep & ~gmask_reg[PSCR_B_KEEP_AMP];
      // R9: inverted sense, set saves power but slows wake up
      ctl.bandgap_off         <= sleep & gmask_reg[PSCR_B_BG_OFF];
      ctl.sleep_active        <= sleep;
      ctl.single_ended_clock  <= se_clk;
      ctl.reference_mode      <= ref_sel;
    end
  end
endmodule
`default_nettype wire

// ===== tb/pscr_regs_properties.sv
`default_nettype none
module pscr_regs_properties
  import pscr_pkg::*;
(
  input wire logic      mclk,
  input wire logic      rst_n,
  input wire logic      spi_sen_n,
  input wire logic      sync_or_sleep_pin,
  input wire logic      global_sleep_trigger,
  input wire pscr_ctl_t ctl,
  input wire logic      sync_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // sleep follows the trigger, sleep side effects trace back to a sleep cause, sync pulses last one cycle
  property p_trig_sleep; global_sleep_trigger |=> ctl.sleep_active; endproperty
  a_trig_sleep: assert property (p_trig_sleep) else $error("no sleep after trigger");
  property p_sleep_cause; ctl.sleep_active |-> $past(global_sleep_trigger || sync_or_sleep_pin); endproperty
  a_sleep_cause: assert property (p_sleep_cause) else $error("sleep without cause");
  property p_bg_sleep; ctl.bandgap_off |-> ctl.sleep_active; endproperty
  a_bg_sleep: assert property (p_bg_sleep) else $error("bandgap off while awake");
  property p_amp_sleep; ctl.ref_amplifier_off |-> ctl.sleep_active; endproperty
  a_amp_sleep: assert property (p_amp_sleep) else $error("amplifier off while awake");
  property p_se_clk; ctl.single_ended_clock |-> ctl.clock_buffer_off; endproperty
  a_se_clk: assert property (p_se_clk) else $error("differential buffer on in single ended mode");
  property p_clk_sleep; ctl.clock_buffer_off && !ctl.single_ended_clock |-> ctl.sleep_active; endproperty
  a_clk_sleep: assert property (p_clk_sleep) else $error("clock buffer off without cause");
  property p_sync_once; sync_pulse |=> !sync_pulse; endproperty
  a_sync_once: assert property (p_sync_once) else $error("sync pulse longer than one cycle");
  // lane 1 buffers of both channels only move through a write, never on their own
  property p_lanes_hold; spi_sen_n [*4] |-> $stable({ctl.chan_a_lane1_off, ctl.chan_b_lane1_off}); endproperty
  a_lanes_hold: assert property (p_lanes_hold) else $error("lane buffer changed without write");
endmodule
bind pscr_regs pscr_regs_properties u_props (.mclk(mclk), .rst_n(rst_n), .spi_sen_n(spi_sen_n),
  .sync_or_sleep_pin(sync_or_sleep_pin), .global_sleep_trigger(global_sleep_trigger), .ctl(ctl), .sync_pulse(sync_pulse));
`default_nettype wire

// ===== tb/pscr_regs_test.sv
`default_nettype none
module pscr_regs_test
  import pscr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic      mclk = 1'b0;
  logic      rst_n = 1'b0;
  logic      sen_n = 1'b1;
  logic      sclk = 1'b0;
  logic      sdi = 1'b0;
  logic      pin = 1'b0;
  logic      refpin = 1'b0;
  logic      trig = 1'b0;
  logic      sdo;
  logic      sdo_oe;
  logic [7:0] oe;
  pscr_ctl_t ctl;
  logic      sync_pulse;
  logic [7:0] rd;
  int        num_errors = 0;
  int        num_checks = 0;
  int        pulses = 0;
  pscr_regs dut (.mclk(mclk), .rst_n(rst_n), .spi_sen_n(sen_n), .spi_sclk(sclk), .spi_sdi(sdi), .spi_sdo(sdo),
    .spi_sdo_oe(sdo_oe), .sync_or_sleep_pin(pin), .reference_buffer_pin(refpin), .global_sleep_trigger(trig),
    .ctl(ctl), .sync_pulse(sync_pulse));
  always #5 mclk = ~mclk;
  // count sync pulses so checks need not hit the exact cycle
  always @(posedge mclk) if (sync_pulse === 1'b1) pulses <= pulses + 1;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one frame, two mclk per sclk phase so every edge is seen
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {rw, a, d};
    sen_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = f[i];
      repeat (2) @(negedge mclk);
      if (i < 8) begin
        rd[i] = sdo;
        oe[i] = sdo_oe;
      end
      sclk = 1'b1;
      repeat (2) @(negedge mclk);
      sclk = 1'b0;
    end
    sen_n = 1'b1;
    repeat (4) @(negedge mclk);
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    xfer(1'b1, a, 8'h00);
    chk(16'(rd), 16'(exp));
    chk(16'(oe), 16'hff);
  endtask
  function automatic logic [15:0] slp();
    return 16'({ctl.clock_buffer_off, ctl.ref_amplifier_off, ctl.bandgap_off, ctl.sleep_active});
  endfunction
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // a hang counts as a failure
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
  initial begin
    int p;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    rchk(PSCR_OFS_OUTPWR, 8'h00);
    rchk(PSCR_OFS_MASK, 8'h00);
    rchk(PSCR_OFS_CTRL, 8'h00);
    rchk(7'h10, 8'h00);
    // walk a single one across the output buffer controls
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, PSCR_OFS_OUTPWR, 8'h01 << i);
      chk(16'({ctl.frame_clock_out_off, ctl.bit_clock_out_off, ctl.chan_a_lane1_off, ctl.chan_a_lane0_off,
        ctl.chan_b_lane1_off, ctl.chan_b_lane0_off}), 16'(8'h01 << i));
    end
    xfer(1'b0, PSCR_OFS_OUTPWR, 8'hff);
    chk(16'(oe), 16'h00);
    rchk(PSCR_OFS_OUTPWR, 8'h3f);
    xfer(1'b0, PSCR_OFS_MASK, 8'hff);
    rchk(PSCR_OFS_MASK, 8'h0e);
    trig = 1'b1;
    repeat (2) @(negedge mclk);
    chk(slp(), 16'h3);
    xfer(1'b0, PSCR_OFS_MASK, 8'h00);
    chk(slp(), 16'hd);
    trig = 1'b0;
    pin = 1'b1;
    repeat (2) @(negedge mclk);
    chk(slp(), 16'hd);
    pin = 1'b0;
    xfer(1'b0, PSCR_OFS_CTRL, 8'h80);
    p = pulses;
    pin = 1'b1;
    repeat (4) @(negedge mclk);
    chk(16'(pulses - p), 16'h1);
    chk(slp(), 16'h0);
    pin = 1'b0;
    // register sync: both edges count, nothing while disabled
    xfer(1'b0, PSCR_OFS_CTRL, 8'h20);
    p = pulses;
    xfer(1'b0, PSCR_OFS_CTRL, 8'h60);
    xfer(1'b0, PSCR_OFS_CTRL, 8'h20);
    chk(16'(pulses - p), 16'h2);
    xfer(1'b0, PSCR_OFS_CTRL, 8'h00);
    xfer(1'b0, PSCR_OFS_CTRL, 8'h40);
    chk(16'(pulses - p), 16'h2);
    chk(16'({ctl.single_ended_clock, ctl.reference_mode}), 16'h0);
    refpin = 1'b1;
    xfer(1'b0, PSCR_OFS_CTRL, 8'h07);
    chk(16'({ctl.single_ended_clock, ctl.reference_mode}), 16'h1);
    for (int c = 0; c < 4; c++) begin
      xfer(1'b0, PSCR_OFS_CTRL, 8'h09 | 8'(c * 2));
      chk(16'({ctl.single_ended_clock, ctl.clock_buffer_off, ctl.reference_mode}), 16'(12 + c));
    end
    xfer(1'b0, PSCR_OFS_CTRL, 8'hff);
    rchk(PSCR_OFS_CTRL, 8'hef);
    finish_test();
  end
endmodule
`default_nettype wire
